// ### oqs_params.svh
// Constants of the output queue scheduler.
`ifndef OQS_PARAMS_SVH
`define OQS_PARAMS_SVH
`define OQS_ADDR_FLAGS 8'h00
`define OQS_ADDR_CMDBUF 8'h02
`define OQS_ADDR_READIDX 8'h01
`define OQS_ADDR_QMAP 8'h10
`define OQS_ADDR_QWEIGHT 8'h11
`define OQS_ADDR_PKTCNT 8'h20
`define OQS_ADDR_BYTECNT 8'h21
`define OQS_ADDR_DOORBELL 8'h30
`define OQS_FLAG_SWB_BIT 1
`define OQS_WDC_MSB 19
`define OQS_BLK_ROUND 12'h07f
`define OQS_BLK_SHIFT 7
`define OQS_BUF_LIMIT 16'h0600
`endif

// ### oqs_pkg.sv
// Types of the output queue scheduler.
package oqs_pkg;
    typedef struct packed {
        logic [7:0] mask;
        logic [2:0] idx;
        logic [1:0] port;
        logic tail;
        logic static_p;
        logic static_q;
        logic s_tail;
    } oqs_qmap_t;
    typedef struct packed {
        logic valid;
        logic [4:0] qid;
    } oqs_sel_t;
    typedef enum logic [1:0] {
        OQS_F_SINGLE_STREAM,
        OQS_F_SINGLE_BUFFERED,
        OQS_F_DOUBLE_READ
    } oqs_fetch_t;
endpackage

// ### oqs_top.sv
// Output queue scheduler with skip-writeback counts and port counters.
`timescale 1ns/1ps
`include "oqs_params.svh"
module oqs_top #(
    parameter int NQ = 32,
    parameter int NP = 4,
    parameter int MAXQ = 8
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Register port.
    input wire logic [7:0] reg_addr_i,
    input wire logic [63:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [63:0] reg_rdata_o,
    // Scheduling request and selection.
    input wire logic [1:0] sel_port_i,
    input wire logic sel_req_i,
    input wire logic sel_ack_i,
    output oqs_pkg::oqs_sel_t sel_o,
    // Packet sent report.
    input wire logic sent_i,
    input wire logic [1:0] sent_port_i,
    input wire logic [4:0] sent_qid_i,
    input wire logic [15:0] sent_bytes_i,
    // Free count request.
    input wire logic free_req_i,
    input wire logic free_chunk_i,
    input wire logic free_last_i,
    input wire logic [6:0] free_addr_lo_i,
    input wire logic [15:0] free_size_i,
    input wire logic [15:0] free_left_i,
    input wire logic [3:0] free_back_i,
    output logic [12:0] free_count_o,
    output logic free_valid_o,
    // Fetch mode choice.
    input wire logic fetch_req_i,
    input wire logic fetch_csum_i,
    input wire logic [15:0] fetch_len_i,
    output oqs_pkg::oqs_fetch_t fetch_mode_o,
    output logic fetch_valid_o
);
    import oqs_pkg::*;
    if (NQ != 32 || NP != 4 || MAXQ != 8)
        $error("oqs_top supports only the default sizes.");

    typedef enum {S_IDLE, S_SCAN, S_HOLD} oqs_state_t;

    oqs_qmap_t qmap_reg [NQ];
    logic [19:0] db_reg [NQ];
    logic [2:0] round_reg [NP];
    logic [2:0] pos_reg [NP];
    logic [31:0] pkt_cnt_reg [NP];
    logic [47:0] byte_cnt_reg [NP];
    logic [4:0] base_reg [NP];
    logic [2:0] maxi_reg [NP];
    logic [2:0] nstat_reg [NP];
    logic [3:0] flags_reg;
    logic [12:0] cmdbuf_size_reg;
    logic [7:0] ridx_reg;
    logic [7:0] rinc_reg;
    oqs_state_t state_reg;
    logic [1:0] port_reg;
    logic [3:0] loops_reg;
    oqs_sel_t sel_reg;
    logic [63:0] rdata_reg;
    logic [12:0] free_count_reg;
    logic free_valid_reg;
    oqs_fetch_t fetch_mode_reg;
    logic fetch_valid_reg;
    // Returns true when the queue has work and a nonzero mask.
    function automatic logic q_ready(input oqs_qmap_t m, input logic [19:0] d);
        q_ready = (m.mask != 8'h00) && (d != 20'h00000);
    endfunction

    // Port configuration derived from the map entries.
    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            base_reg[p] = 5'h1f;
            maxi_reg[p] = 3'h0;
            nstat_reg[p] = 3'h0;
            for (int q = NQ - 1; q >= 0; q--)
            begin
                if (qmap_reg[q].port == p[1:0] && qmap_reg[q].mask != 8'h00 ||
                    qmap_reg[q].port == p[1:0] && qmap_reg[q].tail)
                    base_reg[p] = q[4:0] - {2'h0, qmap_reg[q].idx};
                if (qmap_reg[q].port == p[1:0] && qmap_reg[q].tail)
                    maxi_reg[p] = qmap_reg[q].idx;
                if (qmap_reg[q].port == p[1:0] && qmap_reg[q].s_tail)
                    nstat_reg[p] = qmap_reg[q].idx + 3'h1;
            end
        end
    end

    // Scan state: any ready queue on the port.
    logic port_any;
    logic is_static;
    logic [2:0] rel_q;
    logic [4:0] cur_q;
    logic part;
    always_comb
    begin
        port_any = 1'b0;
        for (int i = 0; i < MAXQ; i++)
            if (i[2:0] <= maxi_reg[sel_port_i] &&
                q_ready(qmap_reg[base_reg[sel_port_i] + i[4:0]],
                        db_reg[base_reg[sel_port_i] + i[4:0]]))
                port_any = 1'b1;
        is_static = {1'b0, loops_reg[2:0]} < {1'b0, nstat_reg[port_reg]} &&
                    !loops_reg[3];
        rel_q = is_static ? loops_reg[2:0] : pos_reg[port_reg];
        cur_q = base_reg[port_reg] + {2'h0, rel_q};
        part = qmap_reg[cur_q].mask[round_reg[port_reg]];
    end

    // Selection sequencer.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= S_IDLE;
            port_reg <= 2'h0;
            loops_reg <= 4'h0;
            sel_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                S_IDLE:
                    if (sel_req_i && flags_reg[0] && port_any)
                    begin
                        port_reg <= sel_port_i;
                        loops_reg <= 4'h0;
                        state_reg <= S_SCAN;
                    end
                S_SCAN:
                begin
                    if (part && db_reg[cur_q] != 20'h00000)
                    begin
                        sel_reg.valid <= 1'b1;
                        sel_reg.qid <= cur_q;
                        state_reg <= S_HOLD;
                    end
                    if (!loops_reg[3])
                        loops_reg <= loops_reg + 4'h1;
                end
                S_HOLD:
                    if (sel_ack_i)
                    begin
                        sel_reg.valid <= 1'b0;
                        state_reg <= S_IDLE;
                    end
            endcase
        end
    end

    // Per-port round and position.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            for (int p = 0; p < NP; p++)
            begin
                round_reg[p] <= 3'h0;
                pos_reg[p] <= 3'h0;
            end
        end
        else if (state_reg == S_SCAN && !is_static)
        begin
            if (pos_reg[port_reg] >= maxi_reg[port_reg])
            begin
                round_reg[port_reg] <= round_reg[port_reg] + 3'h1;
                pos_reg[port_reg] <= nstat_reg[port_reg];
            end
            else
                pos_reg[port_reg] <= pos_reg[port_reg] + 3'h1;
        end
    end

    // Queue map, weights and doorbells.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            for (int q = 0; q < NQ; q++)
            begin
                qmap_reg[q] <= '0;
                db_reg[q] <= 20'h00000;
            end
        end
        else
        begin
            for (int q = 0; q < NQ; q++)
            begin
                if (reg_wr_i && reg_addr_i == `OQS_ADDR_QMAP &&
                    reg_wdata_i[4:0] == q[4:0])
                    qmap_reg[q] <= reg_wdata_i[32:16];
                if (reg_wr_i && reg_addr_i == `OQS_ADDR_QWEIGHT &&
                    reg_wdata_i[4:0] == q[4:0])
                    qmap_reg[q].mask <= reg_wdata_i[15:8];
                if (reg_wr_i && reg_addr_i == `OQS_ADDR_DOORBELL &&
                    reg_wdata_i[56:52] == q[4:0])
                    db_reg[q] <= db_reg[q] + reg_wdata_i[`OQS_WDC_MSB:0]
                                 - ((sent_i && sent_qid_i == q[4:0]) ?
                                    20'h1 : 20'h0);
                else if (sent_i && sent_qid_i == q[4:0] && db_reg[q] != 0)
                    db_reg[q] <= db_reg[q] - 20'h1;
            end
        end
    end

    // Flags, command buffer and read index.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            flags_reg <= 4'h0;
            cmdbuf_size_reg <= 13'h0000;
            ridx_reg <= 8'h00;
            rinc_reg <= 8'h00;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == `OQS_ADDR_FLAGS)
                flags_reg <= {1'b0, reg_wdata_i[2:0]};
            if (reg_wr_i && reg_addr_i == `OQS_ADDR_CMDBUF)
                cmdbuf_size_reg <= reg_wdata_i[12:0];
            if (reg_wr_i && reg_addr_i == `OQS_ADDR_READIDX)
            begin
                ridx_reg <= reg_wdata_i[7:0];
                rinc_reg <= reg_wdata_i[15:8];
            end
            else if (reg_rd_i)
                ridx_reg <= ridx_reg + rinc_reg;
        end
    end

    // Port counters.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            for (int p = 0; p < NP; p++)
            begin
                pkt_cnt_reg[p] <= 32'h0;
                byte_cnt_reg[p] <= 48'h0;
            end
        end
        else if (sent_i)
        begin
            pkt_cnt_reg[sent_port_i] <= pkt_cnt_reg[sent_port_i] + 32'h1;
            byte_cnt_reg[sent_port_i] <= byte_cnt_reg[sent_port_i] +
                                         {32'h0, sent_bytes_i};
        end
    end

    // Register read data.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            rdata_reg <= 64'h0;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `OQS_ADDR_FLAGS: rdata_reg <= {60'h0, 1'b0, flags_reg[2:0]};
                `OQS_ADDR_CMDBUF: rdata_reg <= {51'h0, cmdbuf_size_reg};
                `OQS_ADDR_READIDX: rdata_reg <= {48'h0, rinc_reg, ridx_reg};
                `OQS_ADDR_PKTCNT:
                    rdata_reg <= {32'h0, pkt_cnt_reg[ridx_reg[1:0]]};
                `OQS_ADDR_BYTECNT:
                    rdata_reg <= {16'h0, byte_cnt_reg[ridx_reg[1:0]]};
                default: rdata_reg <= 64'h0;
            endcase
        end
        else
            rdata_reg <= 64'h0;
    end

    // Skip-writeback count.
    logic [15:0] used_size;
    logic [17:0] seg_sum;
    logic [16:0] chunk_sum;
    always_comb
    begin
        used_size = (free_last_i && free_left_i < free_size_i) ?
                    free_left_i : free_size_i;
        seg_sum = {11'h0, free_addr_lo_i} + {2'h0, used_size} +
                  {6'h0, `OQS_BLK_ROUND};
        chunk_sum = {1'b0, cmdbuf_size_reg, 3'h0} + {5'h0, `OQS_BLK_ROUND};
    end
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            free_count_reg <= 13'h0000;
            free_valid_reg <= 1'b0;
        end
        else
        begin
            free_valid_reg <= free_req_i;
            if (!flags_reg[`OQS_FLAG_SWB_BIT])
                free_count_reg <= 13'h0000;
            else if (free_chunk_i)
                free_count_reg <= {3'h0, chunk_sum[16:`OQS_BLK_SHIFT]};
            else
                free_count_reg <= {2'h0, seg_sum[17:`OQS_BLK_SHIFT]} +
                                  {9'h0, free_back_i};
        end
    end

    // Fetch mode choice.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            fetch_mode_reg <= OQS_F_SINGLE_STREAM;
            fetch_valid_reg <= 1'b0;
        end
        else
        begin
            fetch_valid_reg <= fetch_req_i;
            if (!fetch_csum_i)
                fetch_mode_reg <= OQS_F_SINGLE_STREAM;
            else if (fetch_len_i <= `OQS_BUF_LIMIT)
                fetch_mode_reg <= OQS_F_SINGLE_BUFFERED;
            else
                fetch_mode_reg <= OQS_F_DOUBLE_READ;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign sel_o = sel_reg;
    assign free_count_o = free_count_reg;
    assign free_valid_o = free_valid_reg;
    assign fetch_mode_o = fetch_mode_reg;
    assign fetch_valid_o = fetch_valid_reg;
    default clocking oqs_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    sel_hold_a: assert property (sel_reg.valid && !sel_ack_i |=>
        sel_reg.valid && $stable(sel_reg.qid))
        else $error("Selection dropped before accept.");
    sel_ready_a: assert property ($rose(sel_reg.valid) |->
        qmap_reg[sel_reg.qid].mask != 8'h00)
        else $error("Disabled queue selected.");
    swb_off_a: assert property (!flags_reg[1] ##1 !flags_reg[1] |->
        free_count_reg == 13'h0000)
        else $error("Nonzero count while disabled.");
    fetch_big_a: assert property (fetch_csum_i && fetch_len_i >
        `OQS_BUF_LIMIT |=> fetch_mode_reg == OQS_F_DOUBLE_READ)
        else $error("Large checksum packet not read twice.");
    fetch_small_a: assert property (fetch_csum_i && fetch_len_i <=
        `OQS_BUF_LIMIT |=> fetch_mode_reg == OQS_F_SINGLE_BUFFERED)
        else $error("Small checksum packet not buffered.");
    fetch_plain_a: assert property (!fetch_csum_i |=>
        fetch_mode_reg == OQS_F_SINGLE_STREAM)
        else $error("Plain packet not streamed.");
    pkt_count_a: assert property (sent_i |=>
        pkt_cnt_reg[$past(sent_port_i)] ==
        $past(pkt_cnt_reg[sent_port_i]) + 32'h1)
        else $error("Packet counter missed a packet.");
    scan_bound_a: assert property ($rose(state_reg == S_SCAN) |->
        ##[1:80] state_reg == S_HOLD)
        else $error("Scan did not find a queue.");
endmodule // oqs_top

// ### oqs_partner.sv
// Far-side model that accepts selections and reports sent packets.
`timescale 1ns/1ps
module oqs_partner (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Selection and pacing.
    input wire oqs_pkg::oqs_sel_t sel_i,
    input wire logic [3:0] lat_i,
    output logic ack_o,
    // Sent report.
    output logic sent_o,
    output logic [4:0] sent_qid_o,
    output logic [15:0] sent_bytes_o
);
    import oqs_pkg::*;
    logic [3:0] wait_reg;
    // Accepts a held selection after lat_i cycles and reports it sent.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            ack_o <= 1'b0;
            sent_o <= 1'b0;
            sent_qid_o <= 5'h00;
            sent_bytes_o <= 16'h0000;
            wait_reg <= 4'h0;
        end
        else if (sel_i.valid && !ack_o && wait_reg == lat_i)
        begin
            ack_o <= 1'b1;
            sent_o <= 1'b1;
            sent_qid_o <= sel_i.qid;
            sent_bytes_o <= 16'h0040;
            wait_reg <= 4'h0;
        end
        else
        begin
            ack_o <= 1'b0;
            sent_o <= 1'b0;
            sent_qid_o <= ~sent_qid_o;
            sent_bytes_o <= ~sent_bytes_o;
            if (sel_i.valid && !ack_o)
                wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // oqs_partner

// ### oqs_top_tb.sv
// Self-checking testbench of the output queue scheduler.
`timescale 1ns/1ps
module oqs_top_tb;
    import oqs_pkg::*;
    logic core_clk_i, nrst_i, reg_wr_i, reg_rd_i, sel_req_i, sel_ack_i;
    logic [7:0] reg_addr_i;
    logic [63:0] reg_wdata_i, reg_rdata_o;
    logic [1:0] sel_port_i, sent_port_i;
    oqs_sel_t sel_o;
    logic sent_i, free_req_i, free_chunk_i, free_last_i, free_valid_o;
    logic [4:0] sent_qid_i;
    logic [15:0] sent_bytes_i, free_size_i, free_left_i, fetch_len_i;
    logic [6:0] free_addr_lo_i;
    logic [3:0] free_back_i, lat;
    logic [12:0] free_count_o;
    logic fetch_req_i, fetch_csum_i, fetch_valid_o;
    oqs_fetch_t fetch_mode_o;
    int error_cnt, checks_done, sent_cnt;
    logic [4:0] order [12] = '{0, 0, 1, 1, 1, 1, 3, 1, 1, 1, 1, 2};

    oqs_top i_oqs_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .sel_port_i(sel_port_i), .sel_req_i(sel_req_i),
        .sel_ack_i(sel_ack_i), .sel_o(sel_o), .sent_i(sent_i),
        .sent_port_i(sent_port_i), .sent_qid_i(sent_qid_i),
        .sent_bytes_i(sent_bytes_i), .free_req_i(free_req_i),
        .free_chunk_i(free_chunk_i), .free_last_i(free_last_i),
        .free_addr_lo_i(free_addr_lo_i), .free_size_i(free_size_i),
        .free_left_i(free_left_i), .free_back_i(free_back_i),
        .free_count_o(free_count_o), .free_valid_o(free_valid_o),
        .fetch_req_i(fetch_req_i), .fetch_csum_i(fetch_csum_i),
        .fetch_len_i(fetch_len_i), .fetch_mode_o(fetch_mode_o),
        .fetch_valid_o(fetch_valid_o));
    oqs_partner i_oqs_partner (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .sel_i(sel_o), .lat_i(lat), .ack_o(sel_ack_i), .sent_o(sent_i),
        .sent_qid_o(sent_qid_i), .sent_bytes_o(sent_bytes_i));

    initial
    begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
        if (sent_i === 1'b1)
            sent_cnt++;

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [63:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk("reg_rdata", exp, reg_rdata_o);
    endtask
    task automatic qmap(input logic [4:0] q, input logic [7:0] m,
                        input logic [2:0] ix, input logic [3:0] fl);
        wr(8'h10, {31'h0, m, ix, 2'h0, fl, 11'h0, q});
    endtask
    task automatic fr(input logic ck, input logic ls, input logic [15:0] sz,
                      input logic [15:0] lf, input logic [12:0] exp);
        @(posedge core_clk_i);
        free_chunk_i <= ck;
        free_last_i <= ls;
        free_addr_lo_i <= 7'h70;
        free_size_i <= sz;
        free_left_i <= lf;
        free_back_i <= 4'h3;
        free_req_i <= 1'b1;
        @(posedge core_clk_i);
        free_req_i <= 1'b0;
        @(negedge core_clk_i);
        chk("free_valid", 64'h1, {63'h0, free_valid_o});
        chk("free_count", {51'h0, exp}, {51'h0, free_count_o});
    endtask
    task automatic fe(input logic cs, input logic [15:0] len,
                      input logic [1:0] exp);
        @(posedge core_clk_i);
        fetch_csum_i <= cs;
        fetch_len_i <= len;
        fetch_req_i <= 1'b1;
        @(posedge core_clk_i);
        fetch_req_i <= 1'b0;
        @(negedge core_clk_i);
        chk("fetch_valid", 64'h1, {63'h0, fetch_valid_o});
        chk("fetch_mode", {62'h0, exp}, {62'h0, fetch_mode_o});
    endtask
    task automatic sch(input logic [4:0] exp);
        int i;
        @(posedge core_clk_i);
        sel_req_i <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge core_clk_i);
            if (sent_i === 1'b1)
                break;
        end
        sel_req_i <= 1'b0;
        chk("sel_qid", {59'h0, exp}, {59'h0, sent_qid_i});
        @(posedge core_clk_i);
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        error_cnt++;
        finish_test();
    end

    initial
    begin
        int n;
        {nrst_i, reg_wr_i, reg_rd_i, sel_req_i, free_req_i} = 5'h00;
        {fetch_req_i, fetch_csum_i, free_chunk_i, free_last_i} = 4'h0;
        {reg_addr_i, reg_wdata_i, sel_port_i, sent_port_i} = 76'h0;
        {free_addr_lo_i, free_size_i, free_left_i, free_back_i} = 43'h0;
        {fetch_len_i, lat} = 20'h0;
        repeat (3) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        rdchk(8'h00, 64'h0);
        rdchk(8'h02, 64'h0);
        wr(8'h00, 64'h1);
        wr(8'h02, 64'h11);
        fr(1'b1, 1'b0, 16'h00c8, 16'h0032, 13'h0000);
        fr(1'b0, 1'b1, 16'h00c8, 16'h0032, 13'h0000);
        wr(8'h00, 64'hf);
        rdchk(8'h00, 64'h7);
        rdchk(8'h55, 64'h0);
        fr(1'b1, 1'b0, 16'h00c8, 16'h0032, 13'h0002);
        fr(1'b0, 1'b0, 16'h00c8, 16'h0032, 13'h0006);
        fr(1'b0, 1'b1, 16'h00c8, 16'h0032, 13'h0005);
        fe(1'b0, 16'h0700, 2'h0);
        fe(1'b1, 16'h0600, 2'h1);
        fe(1'b1, 16'h0601, 2'h2);
        qmap(5'h00, 8'hff, 3'h0, 4'h7);
        qmap(5'h01, 8'hff, 3'h1, 4'h4);
        qmap(5'h02, 8'h80, 3'h2, 4'h4);
        qmap(5'h03, 8'h08, 3'h3, 4'hc);
        wr(8'h30, {7'h0, 5'h00, 31'h0, 1'b1, 20'h00002});
        wr(8'h30, {7'h0, 5'h01, 32'h0, 20'h00014});
        wr(8'h30, {7'h0, 5'h02, 32'h0, 20'h00001});
        wr(8'h30, {7'h0, 5'h03, 32'h0, 20'h00001});
        for (n = 0; n < 12; n++)
        begin
            lat <= (n > 5) ? 4'h3 : 4'h0;
            sch(order[n]);
        end
        wr(8'h11, {48'h0, 8'h00, 3'h0, 5'h01});
        n = sent_cnt;
        @(posedge core_clk_i);
        sel_req_i <= 1'b1;
        repeat (25) @(posedge core_clk_i);
        chk("sel_valid", 64'h0, {63'h0, sel_o.valid});
        chk("sent_cnt", n, sent_cnt);
        sel_req_i <= 1'b0;
        wr(8'h11, {48'h0, 8'h01, 3'h0, 5'h01});
        sch(5'h01);
        wr(8'h01, 64'h0100);
        rdchk(8'h20, 64'hd);
        rdchk(8'h20, 64'h0);
        wr(8'h01, 64'h0);
        rdchk(8'h21, 64'h340);
        finish_test();
    end
endmodule // oqs_top_tb
